// file: hdl/zqo_defines.svh
`ifndef ZQO_DEFINES_SVH
`define ZQO_DEFINES_SVH

// ****************************************
// clock and analog timing
// ****************************************
`define ZQO_MCLK_PERIOD_PS 5000
`define ZQO_TAONPD_MIN_PS 2000
`define ZQO_TAONPD_MAX_PS 8500
// longest async delay rounds down, never below one cycle
`define ZQO_ASYNC_RAW (`ZQO_TAONPD_MAX_PS / `ZQO_MCLK_PERIOD_PS)
`define ZQO_ASYNC_DLY_CYC ((`ZQO_ASYNC_RAW < 1) ? 1 : `ZQO_ASYNC_RAW)

// ****************************************
// periods in link clock cycles
// ****************************************
`define ZQO_TZQINIT_NCK 10'h200
`define ZQO_TZQOPER_NCK 10'h100
`define ZQO_TZQCS_NCK 10'h040
`define ZQO_TXPDLL_NCK 5'h0A
`define ZQO_CNT_ONE 10'h001
`define ZQO_XP_ONE 5'h01

// ****************************************
// pin vector layout
// ****************************************
`define ZQO_PIN_W 14
`define ZQO_P_CK 0
`define ZQO_P_CKE 1
`define ZQO_P_ODT 2
`define ZQO_P_CSN 3
`define ZQO_P_RASN 4
`define ZQO_P_CASN 5
`define ZQO_P_WEN 6
`define ZQO_P_A10 7
`define ZQO_P_CMP 8
`define ZQO_P_A12 9
`define ZQO_P_WL_LO 10
`define ZQO_P_WL_HI 13

// ****************************************
// misc widths and values
// ****************************************
`define ZQO_CODE_W 6
`define ZQO_CODE_RST 6'h20
`define ZQO_CODE_MAX 6'h3F
`define ZQO_CODE_MIN 6'h00
`define ZQO_AGE_MAX 5'h1F
`define ZQO_PIPE_W 16
`define ZQO_WL_MIN_SYNC 4'h2
`define ZQO_WL_MIN_LOOK 4'h1

`endif

// file: hdl/zqo_pkg.sv
package zqo_pkg;

  typedef enum logic [2:0] {
    ZQ_IDLE = 3'h1,
    ZQ_CAL = 3'h2,
    ZQ_XFER = 3'h4
  } zqo_state_e;

  typedef logic [9:0] zqo_cnt_t;

endpackage : zqo_pkg

// file: hdl/zqo_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "zqo_defines.svh"

module zqo_ctrl (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  // link pins
  input wire logic CK_I,
  input wire logic CKE_I,
  input wire logic ODT_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic A10_I,
  // configuration straps
  input wire logic MR0_A12_I,
  input wire logic [3:0] WL_I,
  // calibration comparator
  input wire logic ZQ_CMP_I,
  // termination
  output logic RTT_ON_O,
  output logic RTT_EITHER_O,
  // calibration status
  output logic ZQ_BUSY_O,
  output logic ZQ_CURRENT_EN_O,
  output logic [`ZQO_CODE_W-1:0] IMP_CODE_O,
  output logic IMP_UPDATE_O
);
  import zqo_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [`ZQO_PIN_W-1:0] pin_raw;
  logic [`ZQO_PIN_W-1:0] pin_m;
  logic [`ZQO_PIN_W-1:0] pin_s;
  logic ck_d;

  assign pin_raw = {WL_I, MR0_A12_I, ZQ_CMP_I, A10_I, WE_N_I, CAS_N_I, RAS_N_I,
                    CS_N_I, ODT_I, CKE_I, CK_I};
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      pin_m <= '0;
      pin_s <= '0;
      ck_d <= 1'b0;
    end else begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
      ck_d <= pin_s[`ZQO_P_CK];
    end
  end

  logic ck_rise;
  logic cke_s;
  logic odt_s;
  logic cmp_s;
  logic dll_frozen;
  logic [3:0] wl;
  logic zq_cmd;
  logic zq_long;

  assign ck_rise = pin_s[`ZQO_P_CK] & ~ck_d;
  assign cke_s = pin_s[`ZQO_P_CKE];
  assign odt_s = pin_s[`ZQO_P_ODT];
  assign cmp_s = pin_s[`ZQO_P_CMP];
  assign dll_frozen = ~pin_s[`ZQO_P_A12];
  assign wl = pin_s[`ZQO_P_WL_HI:`ZQO_P_WL_LO];
  // cs low, ras high, cas high, we low; a10 picks long or short
  assign zq_cmd = ~pin_s[`ZQO_P_CSN] & pin_s[`ZQO_P_RASN] & pin_s[`ZQO_P_CASN]
                  & ~pin_s[`ZQO_P_WEN];
  assign zq_long = pin_s[`ZQO_P_A10];

  // ****************************************
  // power-down and odt tracking
  // ****************************************
  logic cke_reg;
  logic next_cke_reg;
  logic pd;
  logic next_pd;
  logic [4:0] xp_cnt;
  logic [4:0] next_xp_cnt;
  logic [4:0] odt_age;
  logic [4:0] next_odt_age;
  logic odt_reg;
  logic next_odt_reg;
  logic [`ZQO_PIPE_W-1:0] odt_pipe;
  logic [`ZQO_PIPE_W-1:0] next_odt_pipe;
  logic late_odt;
  logic next_late_odt;
  logic [3:0] tanpd;
  logic [3:0] odtl;

  // tANPD = WL - 1, in link cycles before the registering edge
  assign tanpd = (wl < `ZQO_WL_MIN_LOOK) ? 4'h0 : (wl - `ZQO_WL_MIN_LOOK);
  assign odtl = (wl < `ZQO_WL_MIN_SYNC) ? 4'h0 : (wl - `ZQO_WL_MIN_SYNC);

  always_comb begin
    next_cke_reg = cke_reg;
    next_pd = pd;
    next_xp_cnt = xp_cnt;
    next_odt_age = odt_age;
    next_odt_reg = odt_reg;
    next_odt_pipe = odt_pipe;
    next_late_odt = late_odt;
    if (ck_rise) begin
      next_cke_reg = cke_s;
      next_odt_reg = odt_s;
      next_odt_pipe = {odt_pipe[`ZQO_PIPE_W-2:0], odt_s};
      if (odt_s != odt_reg) begin
        next_odt_age = 5'h00;
      end else if (odt_age != `ZQO_AGE_MAX) begin
        next_odt_age = odt_age + `ZQO_XP_ONE;
      end
      if (xp_cnt != 5'h00) begin
        next_xp_cnt = xp_cnt - `ZQO_XP_ONE;
      end
      // entry: first cycle cke registered low, only with dll frozen and ZQ_BUSY_O low
      if (cke_reg && !cke_s && dll_frozen && !ZQ_BUSY_O) begin
        next_pd = 1'b1;
        // odt moved inside the entry lookback; keep flag up
        next_late_odt = ({1'b0, tanpd} > odt_age);
      end
      // exit: first cycle cke registered high opens the tXPDLL tail
      if (pd && !cke_reg && cke_s) begin
        next_pd = 1'b0;
        next_xp_cnt = `ZQO_TXPDLL_NCK;
        next_late_odt = 1'b0;
      end
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      cke_reg <= 1'b0;
      pd <= 1'b0;
      xp_cnt <= 5'h00;
      odt_age <= `ZQO_AGE_MAX;
      odt_reg <= 1'b0;
      odt_pipe <= '0;
      late_odt <= 1'b0;
    end else begin
      cke_reg <= next_cke_reg;
      pd <= next_pd;
      xp_cnt <= next_xp_cnt;
      odt_age <= next_odt_age;
      odt_reg <= next_odt_reg;
      odt_pipe <= next_odt_pipe;
      late_odt <= next_late_odt;
    end
  end

  // ****************************************
  // termination response
  // ****************************************
  // one registered delay line serves both edges; analog spread stays in bounds
  logic [`ZQO_ASYNC_DLY_CYC-1:0] async_line;
  logic [`ZQO_ASYNC_DLY_CYC-1:0] next_async_line;
  logic either;
  logic next_rtt;

  // pre-exit part of the window lies in power-down, tail is xp_cnt
  assign either = pd | (xp_cnt != 5'h00) | late_odt;

  always_comb begin
    next_async_line = (`ZQO_ASYNC_DLY_CYC)'({async_line, odt_s});
    // in the window the async answer is used: it lands at the late bound, rounded down
    if (either) begin
      next_rtt = async_line[`ZQO_ASYNC_DLY_CYC-1];
    end else begin
      next_rtt = odt_pipe[odtl];
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      async_line <= '0;
      RTT_ON_O <= 1'b0;
      RTT_EITHER_O <= 1'b0;
    end else begin
      async_line <= next_async_line;
      RTT_ON_O <= next_rtt;
      RTT_EITHER_O <= either;
    end
  end

  // ****************************************
  // calibration engine
  // ****************************************
  zqo_state_e state;
  zqo_state_e next_state;
  zqo_cnt_t cal_cnt;
  zqo_cnt_t next_cal_cnt;
  logic done_long;
  logic next_done_long;
  logic [`ZQO_CODE_W-1:0] code;
  logic [`ZQO_CODE_W-1:0] next_code;
  logic [`ZQO_CODE_W-1:0] next_imp;
  logic next_upd;

  always_comb begin
    next_state = state;
    next_cal_cnt = cal_cnt;
    next_done_long = done_long;
    next_code = code;
    next_imp = IMP_CODE_O;
    next_upd = 1'b0;
    case (state)
      ZQ_IDLE: begin
        // only an explicit command starts a run, never self-refresh exit
        if (ck_rise && cke_s && zq_cmd) begin
          next_state = ZQ_CAL;
          if (!zq_long) begin
            next_cal_cnt = `ZQO_TZQCS_NCK;
          end else if (!done_long) begin
            next_cal_cnt = `ZQO_TZQINIT_NCK;
            next_done_long = 1'b1;
          end else begin
            next_cal_cnt = `ZQO_TZQOPER_NCK;
          end
        end
      end
      ZQ_CAL: begin
        // one code step per link cycle: 64 steps cover the whole range
        if (ck_rise) begin
          if (cmp_s && code != `ZQO_CODE_MAX) begin
            next_code = code + 6'h01;
          end else if (!cmp_s && code != `ZQO_CODE_MIN) begin
            next_code = code - 6'h01;
          end
          // leaves one cycle early so the transfer lands inside the period
          if (cal_cnt <= `ZQO_CNT_ONE) begin
            next_state = ZQ_XFER;
          end else begin
            next_cal_cnt = cal_cnt - `ZQO_CNT_ONE;
          end
        end
      end
      ZQ_XFER: begin
        next_imp = code;
        next_upd = 1'b1;
        next_cal_cnt = '0;
        next_state = ZQ_IDLE;
      end
      default: begin
        next_state = ZQ_IDLE;
      end
    endcase
  end
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      state <= ZQ_IDLE;
      cal_cnt <= '0;
      done_long <= 1'b0;
      code <= `ZQO_CODE_RST;
      IMP_CODE_O <= `ZQO_CODE_RST;
      IMP_UPDATE_O <= 1'b0;
      ZQ_BUSY_O <= 1'b0;
      ZQ_CURRENT_EN_O <= 1'b0;
    end else begin
      state <= next_state;
      cal_cnt <= next_cal_cnt;
      done_long <= next_done_long;
      code <= next_code;
      IMP_CODE_O <= next_imp;
      IMP_UPDATE_O <= next_upd;
      ZQ_BUSY_O <= (next_state != ZQ_IDLE);
      // current path only while the comparator is in use
      ZQ_CURRENT_EN_O <= (next_state == ZQ_CAL);
    end
  end

endmodule : zqo_ctrl

`default_nettype wire

// file: testbench/zqo_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "zqo_defines.svh"
module zqo_ctrl_monitor (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  // watched pins
  input wire logic ODT_I,
  input wire logic MR0_A12_I,
  input wire logic RTT_ON_O,
  input wire logic RTT_EITHER_O,
  input wire logic ZQ_BUSY_O,
  input wire logic ZQ_CURRENT_EN_O,
  input wire logic [`ZQO_CODE_W-1:0] IMP_CODE_O,
  input wire logic IMP_UPDATE_O
);
  // ****************************************
  // odt hold counter
  // ****************************************
  // one ck period plus sync must pass before the async path is judged
  logic [4:0] hold;
  logic [4:0] next_hold;
  logic odt_q;
  logic next_odt_q;
  always_comb begin
    next_odt_q = ODT_I;
    next_hold = 5'h00;
    if (RESETN_I && RTT_EITHER_O && ODT_I == odt_q)
      next_hold = hold + 5'(hold != 5'h1F);
  end
  always_ff @(posedge MCLK_I) begin
    odt_q <= next_odt_q;
    hold <= next_hold;
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  chk_busy_starts_cal: assert property ($rose(ZQ_BUSY_O) |-> ZQ_CURRENT_EN_O)
    else $error("busy without engine");
  chk_update_ends_busy: assert property (IMP_UPDATE_O |-> !ZQ_BUSY_O && $past(ZQ_BUSY_O))
    else $error("update outside busy");
  chk_update_pulse: assert property (IMP_UPDATE_O |=> !IMP_UPDATE_O)
    else $error("update too long");
  chk_code_hold: assert property (!IMP_UPDATE_O |-> $stable(IMP_CODE_O))
    else $error("code moved without update");
  chk_current_idle: assert property (!ZQ_BUSY_O |-> !ZQ_CURRENT_EN_O)
    else $error("current path on while idle");
  chk_current_then_update: assert property ($fell(ZQ_CURRENT_EN_O) |-> ##[0:2] IMP_UPDATE_O)
    else $error("no transfer after engine");
  chk_dll_on_sync: assert property (MR0_A12_I && !RTT_EITHER_O |=> !RTT_EITHER_O)
    else $error("window with dll on");
  chk_async_rtt: assert property (hold == 5'h18 |-> RTT_ON_O == ODT_I)
    else $error("termination lags odt");
endmodule : zqo_ctrl_monitor
`default_nettype wire

// file: testbench/zqo_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "zqo_defines.svh"
module zqo_host_model (
  // link pins
  output logic ck_o,
  output logic cke_o,
  output logic odt_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic a10_o
);
  logic long_done;
  initial begin
    {ck_o, cke_o, odt_o, long_done} = 4'h4;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o, a10_o} = 5'h1A;
  end
  // ddr clock runs free, the device samples cke on every rising ck edge
  always #40 ck_o = ~ck_o;
  task automatic pin(input logic cke, input logic odt);
    @(negedge ck_o);
    cke_o = cke;
    odt_o = odt;
  endtask : pin
  task automatic zq_cmd(input logic long_cal);
    int quiet;
    // banks idle with tRP met, no self-refresh exit pending
    quiet = int'(!long_cal ? `ZQO_TZQCS_NCK :
      long_done ? `ZQO_TZQOPER_NCK : `ZQO_TZQINIT_NCK);
    pin(1'b1, 1'b0);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o, a10_o} = {4'h6, long_cal};
    long_done = long_done | long_cal;
    @(negedge ck_o);
    cs_n_o = 1'b1;
    {ras_n_o, cas_n_o, we_n_o, a10_o} = ~{ras_n_o, cas_n_o, we_n_o, a10_o};
    // channel silent, lone device on the resistor, dq left floating
    repeat (quiet) @(negedge ck_o);
  endtask : zq_cmd
endmodule : zqo_host_model
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "zqo_defines.svh"
module testbench;
  // ****************************************
  // clock, pins and counters
  // ****************************************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic a12 = 1'b1;
  logic [5:0] tgt = 6'h2A;
  logic ck, cke, odt, cs_n, ras_n, cas_n, we_n, a10;
  logic rtt, either, busy, cur, upd;
  logic [5:0] code;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int ck_busy = 0;
  always #2.5 mclk = ~mclk;
  zqo_host_model zqo_host_model_i (.ck_o(ck), .cke_o(cke), .odt_o(odt), .cs_n_o(cs_n),
    .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .a10_o(a10));
  // comparator stands in for the resistor: trial code under target reads as too low
  logic cmp;
  assign cmp = (zqo_ctrl_i.code < tgt);
  zqo_ctrl zqo_ctrl_i (.MCLK_I(mclk), .RESETN_I(rst_n), .CK_I(ck), .CKE_I(cke), .ODT_I(odt),
    .CS_N_I(cs_n), .RAS_N_I(ras_n), .CAS_N_I(cas_n), .WE_N_I(we_n), .A10_I(a10),
    .MR0_A12_I(a12), .WL_I(4'h5), .ZQ_CMP_I(cmp), .RTT_ON_O(rtt),
    .RTT_EITHER_O(either), .ZQ_BUSY_O(busy), .ZQ_CURRENT_EN_O(cur), .IMP_CODE_O(code),
    .IMP_UPDATE_O(upd));
  always @(posedge ck) if (busy === 1'b1) ck_busy++;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 32'h9C40) begin
      fail_count++;
      test_done();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %0h want %0h", $time, what, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic run_cal(input logic long_cal, input int n_exp);
    int cyc;
    ck_busy = 0;
    fork
      zqo_host_model_i.zq_cmd(long_cal);
      begin
        for (cyc = 0; cyc < 12000 && upd !== 1'b1; cyc++) step(1);
        check(upd, 1'b1, "update seen");
        check(ck_busy >= n_exp - 1 && ck_busy <= n_exp + 1, 1'b1, "length");
        check(code >= tgt - 1 && code <= tgt + 1, 1'b1, "code");
        check(cur, 1'b0, "current");
      end
    join
  endtask : run_cal
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_state;
    check(code, 10'h020, "reset code");
    check({busy, cur, either, rtt}, 10'h000, "reset flags");
  endtask : t_reset_state
  task automatic t_dll_on;
    zqo_host_model_i.pin(1'b0, 1'b0);
    repeat (8) @(negedge ck);
    check(either, 1'b0, "dll on");
    zqo_host_model_i.pin(1'b1, 1'b0);
    repeat (16) @(negedge ck);
  endtask : t_dll_on
  task automatic t_cals;
    run_cal(1'b1, int'(`ZQO_TZQINIT_NCK));
    run_cal(1'b1, int'(`ZQO_TZQOPER_NCK));
    step(1);
    tgt = 6'h2C;
    run_cal(1'b0, int'(`ZQO_TZQCS_NCK));
  endtask : t_cals
  task automatic t_pd_window;
    step(1);
    a12 = 1'b0;
    zqo_host_model_i.pin(1'b0, 1'b0);
    repeat (4) @(negedge ck);
    check(either, 1'b1, "pd window");
    zqo_host_model_i.pin(1'b0, 1'b1);
    @(posedge ck);
    step(8);
    check(rtt, 1'b1, "async on");
    zqo_host_model_i.pin(1'b0, 1'b0);
    @(posedge ck);
    step(8);
    check(rtt, 1'b0, "async off");
    zqo_host_model_i.pin(1'b1, 1'b0);
    repeat (8) @(negedge ck);
    check(either, 1'b1, "exit tail");
    repeat (5) @(negedge ck);
    check(either, 1'b0, "exit done");
  endtask : t_pd_window
  task automatic t_sync_odt;
    zqo_host_model_i.pin(1'b1, 1'b1);
    repeat (2) @(negedge ck);
    check(rtt, 1'b0, "sync early");
    repeat (4) @(negedge ck);
    check(rtt, 1'b1, "sync on");
    zqo_host_model_i.pin(1'b1, 1'b0);
    repeat (6) @(negedge ck);
    check(rtt, 1'b0, "sync off");
  endtask : t_sync_odt
  task automatic t_short_pd;
    zqo_host_model_i.pin(1'b0, 1'b0);
    zqo_host_model_i.pin(1'b1, 1'b0);
    repeat (4) @(negedge ck);
    check(either, 1'b1, "short pd");
    zqo_host_model_i.pin(1'b0, 1'b0);
    zqo_host_model_i.pin(1'b1, 1'b0);
    @(negedge ck);
    check(either, 1'b1, "short idle");
    repeat (14) @(negedge ck);
    check(either, 1'b0, "tail over");
    check(busy, 1'b0, "no self cal");
  endtask : t_short_pd
  initial begin
    step(20);
    rst_n = 1'b1;
    step(4);
    t_reset_state();
    t_dll_on();
    t_cals();
    t_pd_window();
    t_sync_odt();
    t_short_pd();
    test_done();
  end
endmodule : testbench
bind zqo_ctrl zqo_ctrl_monitor zqo_ctrl_monitor_i (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I),
  .ODT_I(ODT_I), .MR0_A12_I(MR0_A12_I), .RTT_ON_O(RTT_ON_O), .RTT_EITHER_O(RTT_EITHER_O),
  .ZQ_BUSY_O(ZQ_BUSY_O), .ZQ_CURRENT_EN_O(ZQ_CURRENT_EN_O), .IMP_CODE_O(IMP_CODE_O),
  .IMP_UPDATE_O(IMP_UPDATE_O));
`default_nettype wire
